// >>> inc/ssaw_pkg.sv
// Shared constants and types for the synchronous SRAM address and write control front end.
package ssaw_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_WIDTH = 20;
  localparam int LANE_COUNT = 8;
  localparam int BURST_WIDTH = 2;
  localparam logic [BURST_WIDTH-1:0] BURST_RESET = 2'h0;
  localparam logic [LANE_COUNT-1:0] LANES_NONE = 8'h00;
  localparam logic [LANE_COUNT-1:0] LANES_ALL = 8'hFF;

  // ----------------------------------------------------------------
  // Cycle kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSAW_IDLE = 2'b00,
    SSAW_PROC = 2'b01,
    SSAW_CTRL = 2'b10,
    SSAW_BURST = 2'b11
  } ssaw_cycle_t;
endpackage

// >>> verilog/ssaw_write_decode.sv
// Byte lane write decode for global and qualified byte writes.
`timescale 1ns/1ps
module ssaw_write_decode #(
  parameter int LANES = 8
) (
  input wire logic allLanesWriteN,
  input wire logic laneWriteEnableN,
  input wire logic [LANES-1:0] laneWriteSelN,
  output logic [LANES-1:0] laneWrite
);
  // Global write overrides the selects; byte selects count only with the enable.
  wire logic [LANES-1:0] qualifiedLanes;
  assign qualifiedLanes = laneWriteEnableN ? '0 : ~laneWriteSelN;
  assign laneWrite = !allLanesWriteN ? '1 : qualifiedLanes;
endmodule

// >>> verilog/ssaw_ctrl.sv
// Address capture, burst counter and write control top level.
`timescale 1ns/1ps
// Behaviour
// - Capture address on strobe with chip selected
// - Load low address bits into burst counter
// - Byte selects used only with enable low
// - Global write writes all lanes
// - Advance low steps burst counter only while selected and with no strobe
// - All inputs sampled on rising clock edge
// - Eight lanes each with own select
// - Processor strobe wins when both asserted
// - Chip selects low, high, low polarity
// - Processor strobe ignored if select one high
// - Chip selects checked only on address load
module ssaw_ctrl #(
  parameter int ADDR_W = ssaw_pkg::ADDR_WIDTH,
  parameter int LANES = ssaw_pkg::LANE_COUNT
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_enable_n,
  input wire logic [LANES-1:0] lane_write_sel_n,
  output logic [ADDR_W-1:0] memAddr,
  output logic [LANES-1:0] laneWriteStrobe,
  output logic cycleActive,
  output logic cycleIsWrite,
  output logic cycleIsProc,
  output logic selected
);
  import ssaw_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // These are declared ahead of the decode, which reads the selection state.
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [BURST_WIDTH-1:0] burst_reg, burst_next;
  logic selected_reg, selected_next;
  logic [LANES-1:0] lanes_reg;
  logic active_reg;
  ssaw_cycle_t cycle_reg, cycle_next;

  // ----------------------------------------------------------------
  // Strobe and select decode
  // ----------------------------------------------------------------
  // Select polarity decode.
  wire logic chipActive;
  assign chipActive = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  // Processor strobe gated by select one.
  wire logic procStrobe;
  assign procStrobe = !proc_addr_strobe_n && !chip_sel_a_n;
  wire logic ctrlStrobe;
  assign ctrlStrobe = !ctrl_addr_strobe_n && !procStrobe;
  wire logic anyStrobe;
  assign anyStrobe = procStrobe || ctrlStrobe;
  wire logic loadAddr;
  assign loadAddr = anyStrobe && chipActive;
  // A strobe with the chip unselected deselects the device.
  wire logic deselect;
  assign deselect = anyStrobe && !chipActive;
  // An advance while deselected is dropped, so a stray pulse on a shared bus cannot
  // move a counter that belongs to another device.
  // Advance only steps a selected burst; selects are not consulted here.
  wire logic stepBurst;
  assign stepBurst = !anyStrobe && !burst_advance_n && selected_reg;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire logic [LANES-1:0] laneDecoded;
  ssaw_write_decode #(.LANES(LANES)) u_decode (
    .allLanesWriteN(all_lanes_write_n),
    .laneWriteEnableN(lane_write_enable_n),
    .laneWriteSelN(lane_write_sel_n),
    .laneWrite(laneDecoded)
  );
  // Lanes are decoded only on live beats, so write controls seen while deselected are dropped.
  wire logic beatActive;
  assign beatActive = loadAddr || stepBurst || (!anyStrobe && selected_reg);
  wire logic [LANES-1:0] laneCycle;
  assign laneCycle = beatActive ? laneDecoded : LANES_NONE;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // The counter wraps linearly from three to zero; the interleaved order is not offered,
  // so a master that expects it must reload the address instead of bursting.
  // Counter loads low bits, and steps on advance.
  assign burst_next = loadAddr ? addrIn[BURST_WIDTH-1:0] :
                      stepBurst ? BURST_WIDTH'(burst_reg + 1'b1) : burst_reg;
  assign addr_next = loadAddr ? addrIn : addr_reg;
  assign selected_next = loadAddr ? 1'b1 : (deselect ? 1'b0 : selected_reg);
  assign cycle_next = loadAddr ? (procStrobe ? SSAW_PROC : SSAW_CTRL) :
                      stepBurst ? SSAW_BURST : (deselect ? SSAW_IDLE : cycle_reg);

  // Everything is sampled on the rising edge.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_reg <= '0;
      burst_reg <= BURST_RESET;
      selected_reg <= 1'b0;
      lanes_reg <= LANES_NONE;
      active_reg <= 1'b0;
      cycle_reg <= SSAW_IDLE;
    end else begin
      addr_reg <= addr_next;
      burst_reg <= burst_next;
      selected_reg <= selected_next;
      lanes_reg <= laneCycle;
      active_reg <= beatActive;
      cycle_reg <= cycle_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The low address bits come from the counter so bursts need no new address.
  logic [ADDR_W-1:0] memAddr_reg;
  logic isWrite_reg;
  // The processor flag has a flop of its own so that the pin carries no decode glitch.
  // It falls on a burst beat, a controller load and a deselect, and rises only on a processor load.
  logic isProc_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      memAddr_reg <= '0;
      isWrite_reg <= 1'b0;
      isProc_reg <= 1'b0;
    end else begin
      memAddr_reg <= {addr_next[ADDR_W-1:BURST_WIDTH], burst_next};
      isWrite_reg <= |laneCycle;
      isProc_reg <= (cycle_next == SSAW_PROC);
    end
  end
  assign memAddr = memAddr_reg;
  assign laneWriteStrobe = lanes_reg;
  assign cycleActive = active_reg;
  assign cycleIsWrite = isWrite_reg;
  assign cycleIsProc = isProc_reg;
  assign selected = selected_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Checks sleep while reset is high, since the registers only settle at an edge that sees it.

  a_load_address: assert property (loadAddr |=> memAddr == $past(addrIn))
    else $error("Address not captured on selected strobe.");
  a_burst_load: assert property (loadAddr |=> burst_reg == $past(addrIn[1:0]))
    else $error("Burst counter not loaded.");
  a_byte_qualify: assert property (all_lanes_write_n && !lane_write_enable_n && beatActive
    |=> laneWriteStrobe == $past(~lane_write_sel_n))
    else $error("Byte write lanes wrong.");
  a_byte_no_enable: assert property (all_lanes_write_n && lane_write_enable_n
    |=> laneWriteStrobe == LANES_NONE)
    else $error("Lanes written without enable.");
  a_global_write: assert property (!all_lanes_write_n && beatActive |=> laneWriteStrobe == LANES_ALL)
    else $error("Global write missed lanes.");
  a_burst_step: assert property (stepBurst |=> burst_reg == BURST_WIDTH'($past(burst_reg) + 1'b1))
    else $error("Burst counter did not step.");
  a_burst_hold: assert property (!loadAddr && burst_advance_n |=> $stable(burst_reg))
    else $error("Burst counter moved without advance.");
  a_proc_priority: assert property (procStrobe && chipActive |=> cycleIsProc)
    else $error("Processor strobe not honoured.");
  a_select_polarity: assert property (anyStrobe && (chip_sel_a_n || !chip_sel_b || chip_sel_c_n)
    |=> !selected && $stable(memAddr))
    else $error("Device selected with inactive select.");
  a_proc_ignored: assert property (!proc_addr_strobe_n && chip_sel_a_n && ctrl_addr_strobe_n
    && burst_advance_n |=> $stable(selected) && $stable(memAddr) && $stable(cycleIsProc))
    else $error("Processor strobe honoured with select one high.");
  a_burst_selects: assert property (stepBurst && chip_sel_b == 1'b0 |=> selected)
    else $error("Selects re-evaluated during burst.");
  a_read_cycle: assert property (cycleActive && laneWriteStrobe == LANES_NONE |-> !cycleIsWrite)
    else $error("Read flagged as write.");

  a_read_no_write: assert property (beatActive && all_lanes_write_n
    && (lane_write_enable_n || &lane_write_sel_n)
    |=> laneWriteStrobe == LANES_NONE && !cycleIsWrite)
    else $error("Read cycle wrote a lane.");
  a_idle_advance: assert property (!anyStrobe && !selected_reg
    |=> laneWriteStrobe == LANES_NONE && !cycleActive && $stable(memAddr))
    else $error("Deselected device acted on a beat.");
  a_burst_upper: assert property (stepBurst
    |=> $stable(memAddr[ADDR_W-1:BURST_WIDTH]) && memAddr[BURST_WIDTH-1:0] == burst_reg)
    else $error("Burst step disturbed the upper address.");
  a_select_hold: assert property (!anyStrobe |=> $stable(selected))
    else $error("Selection changed without a strobe.");
  a_load_active: assert property (loadAddr |=> selected && cycleActive)
    else $error("Selected load did not start an access.");
  a_ctrl_load: assert property (ctrlStrobe && chipActive
    |=> selected && !cycleIsProc)
    else $error("Controller load flagged as processor access.");
  a_deselect_clear: assert property (deselect
    |=> !cycleActive && !cycleIsProc && laneWriteStrobe == LANES_NONE)
    else $error("Deselect left an access flagged.");
  a_hold_write: assert property (!anyStrobe && selected_reg && !all_lanes_write_n
    |=> laneWriteStrobe == LANES_ALL && cycleIsWrite)
    else $error("Global write on a held beat missed lanes.");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  // These confirm that the random traffic reaches each kind of cycle.
  c_proc_load: cover property (procStrobe && chipActive);
  c_ctrl_load: cover property (ctrlStrobe && chipActive);
  c_burst_wrap: cover property (stepBurst && burst_reg == 2'h3);
  c_global_write: cover property (!all_lanes_write_n && loadAddr);
  c_deselect: cover property (deselect && selected_reg);
endmodule

// >>> testbench/ssaw_bus_master.sv
// Processor side model driving the strobes, chip selects and write controls.
`timescale 1ns/1ps
module ssaw_bus_master (
  input wire logic [ssaw_pkg::ADDR_WIDTH-1:0] reqAddr,
  input wire logic [7:0] reqCtl,
  input wire logic [ssaw_pkg::LANE_COUNT-1:0] reqLanes,
  output logic [ssaw_pkg::ADDR_WIDTH-1:0] addrIn,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  output logic chip_sel_a_n,
  output logic chip_sel_b,
  output logic chip_sel_c_n,
  output logic all_lanes_write_n,
  output logic lane_write_enable_n,
  output logic [ssaw_pkg::LANE_COUNT-1:0] lane_write_sel_n
);
  import ssaw_pkg::*;
  assign addrIn = reqAddr;
  assign {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n,
    all_lanes_write_n} = reqCtl[7:1];
  // Partial write enable
  // Bit 0 of the request exists only so a scenario can withhold the enable on purpose.
  assign lane_write_enable_n = ~(|reqLanes) | reqCtl[0];
  assign lane_write_sel_n = ~reqLanes;
endmodule

// >>> testbench/tb_sync_sram_addr_write_ctrl.sv
// Self-checking bench for the address capture and write control front end.
`timescale 1ns/1ps
module tb_sync_sram_addr_write_ctrl;
  import ssaw_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic [ADDR_WIDTH-1:0] reqAddr = '0, expAddr = '0;
  logic [7:0] reqCtl = 8'hF6;
  logic [LANE_COUNT-1:0] reqLanes = 8'h00, expLanes = 8'h00;
  logic expSel = 0, expProc = 0, ld, act;
  int num_errors = 0, total_checks = 0, seed = 13;
  wire [ADDR_WIDTH-1:0] addrIn, memAddr;
  wire [LANE_COUNT-1:0] selN, laneWriteStrobe;
  wire procN, ctrlN, advN, csAN, csB, csCN, gwN, beN, cycleActive, cycleIsWrite, cycleIsProc, selected;
  ssaw_bus_master u_ssaw_bus_master (.reqAddr(reqAddr), .reqCtl(reqCtl), .reqLanes(reqLanes), .addrIn(addrIn),
    .proc_addr_strobe_n(procN), .ctrl_addr_strobe_n(ctrlN), .burst_advance_n(advN), .chip_sel_a_n(csAN),
    .chip_sel_b(csB), .chip_sel_c_n(csCN), .all_lanes_write_n(gwN), .lane_write_enable_n(beN),
    .lane_write_sel_n(selN));
  ssaw_ctrl u_ssaw_ctrl (.core_clk(core_clk), .reset(reset), .addrIn(addrIn), .proc_addr_strobe_n(procN),
    .ctrl_addr_strobe_n(ctrlN), .burst_advance_n(advN), .chip_sel_a_n(csAN), .chip_sel_b(csB),
    .chip_sel_c_n(csCN), .all_lanes_write_n(gwN), .lane_write_enable_n(beN), .lane_write_sel_n(selN),
    .memAddr(memAddr), .laneWriteStrobe(laneWriteStrobe), .cycleActive(cycleActive), .cycleIsWrite(cycleIsWrite),
    .cycleIsProc(cycleIsProc), .selected(selected));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  function automatic logic [7:0] decode(input logic g, input logic b, input logic [7:0] s);
    return !g ? LANES_ALL : (!b ? ~s : LANES_NONE);
  endfunction
  // ------------------------------------------------------------
  // Reference model, updated from the pins sampled at each rising edge
  // ------------------------------------------------------------
  task automatic step();
    @(posedge core_clk);
    ld = (!procN && !csAN) || !ctrlN;
    act = !csAN && csB && !csCN;
    if (reset) begin
      expSel = 0;
      expProc = 0;
      expAddr = '0;
    end else if (ld) begin
      expSel = act;
      expProc = act && !procN;
      if (act) expAddr = addrIn;
    end else if (expSel && !advN) begin
      expAddr[1:0] = expAddr[1:0] + 2'h1;
      // A burst beat is no longer the processor's load beat.
      expProc = 0;
    end
    expLanes = (expSel && !reset) ? decode(gwN, beN, selN) : LANES_NONE;
    @(negedge core_clk);
    check(32'(memAddr), 32'(expAddr));
    check(32'(laneWriteStrobe), 32'(expLanes));
    check(32'({cycleIsWrite, cycleIsProc, selected}), 32'({|expLanes, expProc, expSel}));
    check(32'(cycleActive), 32'(expSel));
  endtask
  task automatic cyc(input logic [7:0] ctl, input logic [7:0] lanes, input logic [19:0] a);
    reqCtl = ctl;
    reqLanes = lanes;
    reqAddr = a;
    step();
  endtask
  initial begin
    repeat (3) step();
    reset = 0;
    // Global write load with low bits 3 so the advances wrap to 0.
    cyc(8'h68, 8'h5A, 20'hABCD7);
    // Advances with the selects deasserted must still step the counter.
    repeat (4) cyc(8'hD6, 8'h81, 20'h12340);
    // Both strobes together, then processor strobe with select one high.
    cyc(8'h2A, 8'h00, 20'h55551);
    cyc(8'h7A, 8'h3C, 20'h66662);
    // Deselect, then an advance that must be ignored.
    cyc(8'hAE, 8'hFF, 20'h77773);
    cyc(8'hD6, 8'hFF, 20'h77773);
    // Lane selects with the enable withheld give no write.
    cyc(8'hAB, 8'h0F, 20'h01230);
    // Every chip select combination under the controller strobe.
    for (int cs = 0; cs < 8; cs++) cyc({3'b101, cs[2:0], 2'b10}, 8'h01 << cs, {12'h0, cs[7:0]});
    repeat (300) cyc(8'($random(seed)), 8'($random(seed)), 20'($random(seed)));
    close_out();
  end
  initial begin
    #(25 * 2000);
    num_errors++;
    close_out();
  end
endmodule
